// ### verilog/drs_pkg.sv
// Package: record layout, codes and register map of the diagnostic record builder
package drs_pkg;
    localparam int          DRS_REC_BYTES   = 16;
    localparam int          DRS_BASE_BYTES  = 4;
    localparam int          DRS_SPEC_BYTES  = 12;
    localparam logic [6:0]  DRS_TYPE_DI     = 7'h70;
    localparam logic [6:0]  DRS_TYPE_AI     = 7'h71;
    localparam logic [6:0]  DRS_TYPE_DO     = 7'h72;
    localparam logic [6:0]  DRS_TYPE_AO     = 7'h73;
    localparam logic [6:0]  DRS_TYPE_AIO    = 7'h74;
    localparam logic [7:0]  DRS_BITS_PER_CH = 8'h08;
    localparam logic [7:0]  DRS_NUM_CH      = 8'h08;
    localparam int          DRS_GRP_N       = 3;
    localparam int          DRS_FM_N        = 2;
    localparam int          DRS_IN_N        = 10;
    localparam int          DRS_FM_ERR_POS  = 4;
    // Interrupt events: 10 input lost, 2 integration lost
    localparam int          DRS_EVT_N       = 12;
    // Register byte addresses
    localparam logic [7:0]  DRS_REG_REC0    = 8'h00;
    localparam logic [7:0]  DRS_REG_REC1    = 8'h04;
    localparam logic [7:0]  DRS_REG_REC2    = 8'h08;
    localparam logic [7:0]  DRS_REG_REC3    = 8'h0C;
    localparam logic [7:0]  DRS_REG_CTRL    = 8'h10;
    localparam logic [7:0]  DRS_REG_STAT    = 8'h14;
    localparam logic [7:0]  DRS_REG_IEN     = 8'h18;
    localparam logic [7:0]  DRS_REG_ICLR    = 8'h1C;
    localparam logic [31:0] DRS_CTRL_RST    = 32'h0000_0000;
    localparam logic [1:0]  DRS_RESP_OKAY   = 2'b00;
    localparam logic [1:0]  DRS_RESP_SLVERR = 2'b10;
    typedef enum logic [0:0] {DRS_MODE_FREQ = 1'b0, DRS_MODE_PWM = 1'b1} drs_mode_t;
endpackage

// ### verilog/drs_sticky.sv
// Sticky event flags with set-over-clear
`timescale 1ns/10ps
module drs_sticky #(
    parameter int N = 12
) (
    input  wire logic         mclk_i,
    input  wire logic         rst_i,
    input  wire logic [N-1:0] set_i,
    input  wire logic [N-1:0] clr_i,
    output logic      [N-1:0] flag_o
);
    logic [N-1:0] flag_q;
    logic [N-1:0] flag_d;

    assign flag_d = set_i | (flag_q & ~clr_i);
    assign flag_o = flag_q;

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            flag_q <= '0;
        end else begin
            flag_q <= flag_d;
        end
    end

    chk_set_wins: assert property (@(posedge mclk_i) disable iff (rst_i)
        (set_i != '0) |=> ((flag_q & $past(set_i)) == $past(set_i)))
        else $error("sticky set lost");
endmodule

// ### verilog/drs_axil.sv
// AXI4-Lite slave front end: handshake and address capture
`timescale 1ns/10ps
module drs_axil (
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    input  wire logic        awvalid_i,
    output logic             awready_o,
    input  wire logic [7:0]  awaddr_i,
    input  wire logic        wvalid_i,
    output logic             wready_o,
    input  wire logic [31:0] wdata_i,
    input  wire logic [3:0]  wstrb_i,
    output logic             bvalid_o,
    input  wire logic        bready_i,
    input  wire logic [1:0]  wresp_i,
    input  wire logic        arvalid_i,
    output logic             arready_o,
    input  wire logic [7:0]  araddr_i,
    output logic             rvalid_o,
    input  wire logic        rready_i,
    output logic             wr_o,
    output logic [7:0]       wr_addr_o,
    output logic [31:0]      wr_data_o,
    output logic [3:0]       wr_strb_o,
    output logic             rd_o,
    output logic [7:0]       rd_addr_o
);
    logic        aw_got_q;
    logic        w_got_q;
    logic        bvalid_q;
    logic        rvalid_q;
    logic [7:0]  aw_q;
    logic [31:0] wd_q;
    logic [3:0]  ws_q;
    logic        aw_fire;
    logic        w_fire;
    logic        ar_fire;

    assign awready_o = !aw_got_q && !bvalid_q;
    assign wready_o  = !w_got_q && !bvalid_q;
    assign arready_o = !rvalid_q;
    assign aw_fire   = awvalid_i && awready_o;
    assign w_fire    = wvalid_i && wready_o;
    assign ar_fire   = arvalid_i && arready_o;
    assign wr_o      = aw_got_q && w_got_q && !bvalid_q;
    assign wr_addr_o = aw_q;
    assign wr_data_o = wd_q;
    assign wr_strb_o = ws_q;
    assign rd_o      = ar_fire;
    assign rd_addr_o = araddr_i;
    assign bvalid_o  = bvalid_q;
    assign rvalid_o  = rvalid_q;

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            aw_got_q <= 1'b0;
            w_got_q  <= 1'b0;
            bvalid_q <= 1'b0;
            rvalid_q <= 1'b0;
            aw_q     <= 8'h00;
            wd_q     <= 32'h0000_0000;
            ws_q     <= 4'h0;
        end else begin
            if (aw_fire) begin
                aw_got_q <= 1'b1;
                aw_q     <= awaddr_i;
            end
            if (w_fire) begin
                w_got_q <= 1'b1;
                wd_q    <= wdata_i;
                ws_q    <= wstrb_i;
            end
            if (wr_o) begin
                aw_got_q <= 1'b0;
                w_got_q  <= 1'b0;
                bvalid_q <= 1'b1;
            end else if (bvalid_q && bready_i) begin
                bvalid_q <= 1'b0;
            end
            if (ar_fire) begin
                rvalid_q <= 1'b1;
            end else if (rvalid_q && rready_i) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    logic unused_resp;
    assign unused_resp = ^wresp_i;

    chk_b_follows: assert property (@(posedge mclk_i) disable iff (rst_i)
        wr_o |=> bvalid_o)
        else $error("write response missing");
endmodule

// ### verilog/drs_rec_builder.sv
// Extended diagnostic record set 1 builder with AXI4-Lite access
`timescale 1ns/10ps
// Operation
// - Record is sixteen bytes: four base bytes then twelve specific bytes.
// - Byte 4 bits 6..0 carry channel type code, digital input 70h.
// - Byte 4 bit 7 says whether more channel types follow.
// - Byte 5 holds diagnostic bits per channel, eight.
// - Byte 6 holds number of channels, eight.
// - Byte 7 bits 0..2 flag errors of input groups 0..2.
// - Frequency mode: byte 7 bits 4,5 flag meter errors; 3,6,7 reserved.
// - Pulse width mode: byte 7 carries only bits 0..2.
// - Bytes 8..10 even bits flag lost process interrupt per input.
// - Frequency mode: bytes 12,13 bit 0 flag lost integration-end interrupt.
module drs_rec_builder (
    input  wire logic                    mclk_i,
    input  wire logic                    rst_i,
    input  wire logic [31:0]             base_rec_i,
    input  wire logic [drs_pkg::DRS_GRP_N-1:0] grp_err_i,
    input  wire logic [drs_pkg::DRS_FM_N-1:0]  fm_err_i,
    input  wire logic [drs_pkg::DRS_IN_N-1:0]  in_lost_i,
    input  wire logic [drs_pkg::DRS_FM_N-1:0]  int_lost_i,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    input  wire logic [7:0]              s_axi_awaddr,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    output logic [1:0]                   s_axi_bresp,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    input  wire logic [7:0]              s_axi_araddr,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready,
    output logic [31:0]                  s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output logic                         irq_o
);
    import drs_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [31:0]          ctrl_q;
    logic [DRS_EVT_N-1:0] ien_q;
    logic [DRS_EVT_N-1:0] stat;
    logic [DRS_EVT_N-1:0] clr;
    logic [DRS_EVT_N-1:0] evt;
    logic [DRS_GRP_N-1:0] grp_q;
    logic [DRS_FM_N-1:0]  fm_q;
    logic [31:0]          rdata_q;
    logic [1:0]           rresp_q;
    logic [1:0]           bresp_q;
    logic                 wr;
    logic [7:0]           wr_addr;
    logic [31:0]          wr_data;
    logic [3:0]           wr_strb;
    logic                 rd;
    logic [7:0]           rd_addr;
    drs_mode_t            mode;
    logic                 freq_mode;
    logic [7:0]           rec [DRS_REC_BYTES];
    logic [31:0]          rd_mux;
    logic                 rd_hit;
    logic                 wr_hit;
    logic [31:0]          clr_word;
    logic [31:0]          ien_word;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [7:0] spread4(input logic [3:0] v);
        spread4 = {1'b0, v[3], 1'b0, v[2], 1'b0, v[1], 1'b0, v[0]};
    endfunction

    function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        strb_merge = r;
    endfunction

    function automatic logic [31:0] pack4(input logic [7:0] b0, input logic [7:0] b1,
                                          input logic [7:0] b2, input logic [7:0] b3);
        pack4 = {b3, b2, b1, b0};
    endfunction

    // ------------------------------------------------------------------
    // Control: bit 0 mode, bit 1 more channel types
    // ------------------------------------------------------------------
    assign mode      = drs_mode_t'(ctrl_q[0]);
    assign freq_mode = (mode == DRS_MODE_FREQ);

    // ------------------------------------------------------------------
    // Error flags and lost-interrupt events
    // ------------------------------------------------------------------
    assign evt = {int_lost_i & {DRS_FM_N{freq_mode}}, in_lost_i};

    drs_sticky #(
        .N (DRS_EVT_N)
    ) u_sticky (
        .mclk_i (mclk_i),
        .rst_i  (rst_i),
        .set_i  (evt),
        .clr_i  (clr),
        .flag_o (stat)
    );

    assign irq_o = |(stat & ien_q);

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            grp_q <= '0;
            fm_q  <= '0;
        end else begin
            grp_q <= grp_err_i;
            fm_q  <= fm_err_i;
        end
    end

    // ------------------------------------------------------------------
    // Record assembly
    // ------------------------------------------------------------------
    assign rec[0]  = base_rec_i[7:0];
    assign rec[1]  = base_rec_i[15:8];
    assign rec[2]  = base_rec_i[23:16];
    assign rec[3]  = base_rec_i[31:24];
    assign rec[4]  = {ctrl_q[1], DRS_TYPE_DI};
    assign rec[5]  = DRS_BITS_PER_CH;
    assign rec[6]  = DRS_NUM_CH;
    assign rec[7]  = freq_mode ? {2'b00, fm_q, 1'b0, grp_q}
                               : {5'b00000, grp_q};
    assign rec[8]  = spread4(stat[3:0]);
    assign rec[9]  = spread4(stat[7:4]);
    assign rec[10] = {4'h0, 1'b0, stat[9], 1'b0, stat[8]};
    assign rec[11] = 8'h00;
    assign rec[12] = freq_mode ? {7'h00, stat[10]} : 8'h00;
    assign rec[13] = freq_mode ? {7'h00, stat[11]} : 8'h00;
    assign rec[14] = 8'h00;
    assign rec[15] = 8'h00;

    // ------------------------------------------------------------------
    // Bus front end
    // ------------------------------------------------------------------
    drs_axil u_axil (
        .mclk_i    (mclk_i),
        .rst_i     (rst_i),
        .awvalid_i (s_axi_awvalid),
        .awready_o (s_axi_awready),
        .awaddr_i  (s_axi_awaddr),
        .wvalid_i  (s_axi_wvalid),
        .wready_o  (s_axi_wready),
        .wdata_i   (s_axi_wdata),
        .wstrb_i   (s_axi_wstrb),
        .bvalid_o  (s_axi_bvalid),
        .bready_i  (s_axi_bready),
        .wresp_i   (bresp_q),
        .arvalid_i (s_axi_arvalid),
        .arready_o (s_axi_arready),
        .araddr_i  (s_axi_araddr),
        .rvalid_o  (s_axi_rvalid),
        .rready_i  (s_axi_rready),
        .wr_o      (wr),
        .wr_addr_o (wr_addr),
        .wr_data_o (wr_data),
        .wr_strb_o (wr_strb),
        .rd_o      (rd),
        .rd_addr_o (rd_addr)
    );

    // ------------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------------
    assign wr_hit = (wr_addr == DRS_REG_CTRL) || (wr_addr == DRS_REG_IEN) || (wr_addr == DRS_REG_ICLR);
    assign clr_word = strb_merge(32'h0000_0000, wr_data, wr_strb);
    assign ien_word = strb_merge({20'h00000, ien_q}, wr_data, wr_strb);
    assign clr    = (wr && wr_addr == DRS_REG_ICLR)
                  ? clr_word[DRS_EVT_N-1:0]
                  : '0;

    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b1;
        unique case (rd_addr)
            DRS_REG_REC0: rd_mux = pack4(rec[0], rec[1], rec[2], rec[3]);
            DRS_REG_REC1: rd_mux = pack4(rec[4], rec[5], rec[6], rec[7]);
            DRS_REG_REC2: rd_mux = pack4(rec[8], rec[9], rec[10], rec[11]);
            DRS_REG_REC3: rd_mux = pack4(rec[12], rec[13], rec[14], rec[15]);
            DRS_REG_CTRL: rd_mux = {30'h0000_0000, ctrl_q[1:0]};
            DRS_REG_STAT: rd_mux = {20'h00000, stat};
            DRS_REG_IEN:  rd_mux = {20'h00000, ien_q};
            DRS_REG_ICLR: rd_mux = 32'h0000_0000;
            default:      rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            ctrl_q  <= DRS_CTRL_RST;
            ien_q   <= '0;
            bresp_q <= DRS_RESP_OKAY;
        end else if (wr) begin
            bresp_q <= wr_hit ? DRS_RESP_OKAY : DRS_RESP_SLVERR;
            if (wr_addr == DRS_REG_CTRL) begin
                ctrl_q <= strb_merge(ctrl_q, wr_data, wr_strb) & 32'h0000_0003;
            end
            if (wr_addr == DRS_REG_IEN) begin
                ien_q <= ien_word[DRS_EVT_N-1:0];
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            rdata_q <= 32'h0000_0000;
            rresp_q <= DRS_RESP_OKAY;
        end else if (rd) begin
            rdata_q <= rd_mux;
            rresp_q <= rd_hit ? DRS_RESP_OKAY : DRS_RESP_SLVERR;
        end
    end

    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_bresp = bresp_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    chk_type_code: assert property (@(posedge mclk_i) disable iff (rst_i)
        rec[4][6:0] == 7'h70)
        else $error("channel type wrong");
    chk_more_types: assert property (@(posedge mclk_i) disable iff (rst_i)
        rec[4][7] == ctrl_q[1])
        else $error("more types bit wrong");
    chk_count_bytes: assert property (@(posedge mclk_i) disable iff (rst_i)
        rec[5] == 8'h08 && rec[6] == 8'h08)
        else $error("count bytes wrong");
    chk_group_err: assert property (@(posedge mclk_i) disable iff (rst_i)
        ##1 rec[7][2:0] == $past(grp_err_i))
        else $error("group error bits wrong");
    chk_freq_meter: assert property (@(posedge mclk_i) disable iff (rst_i)
        freq_mode && $stable(ctrl_q) |-> rec[7][5:4] == $past(fm_err_i) && rec[7][7:6] == 2'b00 && !rec[7][3])
        else $error("meter error bits wrong");
    chk_pwm_byte7: assert property (@(posedge mclk_i) disable iff (rst_i)
        !freq_mode |-> rec[7][7:3] == 5'b00000)
        else $error("pwm byte 7 reserved set");
    chk_lost_input: assert property (@(posedge mclk_i) disable iff (rst_i)
        in_lost_i[0] |=> rec[8][0] && rec[8][1] == 1'b0)
        else $error("input lost flag missing");
    chk_int_lost: assert property (@(posedge mclk_i) disable iff (rst_i)
        freq_mode && int_lost_i[1] ##1 freq_mode |-> rec[13] == 8'h01)
        else $error("integration lost flag missing");
    chk_reserved: assert property (@(posedge mclk_i) disable iff (rst_i)
        rec[11] == 8'h00 && rec[14] == 8'h00 && rec[15] == 8'h00 && rec[10][7:4] == 4'h0
        && (freq_mode || (rec[12] == 8'h00 && rec[13] == 8'h00)))
        else $error("reserved byte not zero");
    chk_irq_level: assert property (@(posedge mclk_i) disable iff (rst_i)
        (|(evt & ien_q)) && !wr |=> irq_o)
        else $error("interrupt level wrong");
endmodule

// ### sim/drs_cpu_mdl.sv
// CPU side model: AXI4-Lite master issuing one transfer at a time
`timescale 1ns/10ps
module drs_cpu_mdl (
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    input  wire logic        go_i,
    input  wire logic        we_i,
    input  wire logic        stall_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    output logic             done_o,
    output logic [31:0]      rdata_o,
    output logic [1:0]       resp_o,
    output logic             awvalid_o,
    input  wire logic        awready_i,
    output logic [7:0]       awaddr_o,
    output logic             wvalid_o,
    input  wire logic        wready_i,
    output logic [31:0]      wdata_o,
    output logic [3:0]       wstrb_o,
    input  wire logic        bvalid_i,
    output logic             bready_o,
    input  wire logic [1:0]  bresp_i,
    output logic             arvalid_o,
    input  wire logic        arready_i,
    output logic [7:0]       araddr_o,
    input  wire logic        rvalid_i,
    output logic             rready_o,
    input  wire logic [31:0] rdata_i,
    input  wire logic [1:0]  rresp_i
);
    logic       we_q;
    logic [1:0] wait_q;
    assign wstrb_o = 4'hF;
    always @(posedge mclk_i) begin
        if (rst_i) begin
            {awvalid_o, wvalid_o, arvalid_o, bready_o, rready_o, done_o} <= 6'h00;
            awaddr_o <= 8'h00;
            araddr_o <= 8'h00;
            wdata_o  <= 32'h0000_0000;
            wait_q   <= 2'h0;
            we_q     <= 1'b0;
        end else begin
            done_o <= 1'b0;
            // Released payload keeps changing
            if (!awvalid_o) awaddr_o <= ~awaddr_o;
            if (!wvalid_o) wdata_o <= ~wdata_o;
            if (!arvalid_o) araddr_o <= ~araddr_o;
            if (awvalid_o && awready_i) awvalid_o <= 1'b0;
            if (wvalid_o && wready_i) wvalid_o <= 1'b0;
            if (arvalid_o && arready_i) arvalid_o <= 1'b0;
            if (wait_q != 2'h0) wait_q <= wait_q - 2'h1;
            // Slow answer: ready raised late
            if (wait_q == 2'h1) begin
                bready_o <= we_q;
                rready_o <= !we_q;
            end
            if (bready_o && bvalid_i) begin
                bready_o <= 1'b0;
                resp_o   <= bresp_i;
                done_o   <= 1'b1;
            end
            if (rready_o && rvalid_i) begin
                rready_o <= 1'b0;
                rdata_o  <= rdata_i;
                resp_o   <= rresp_i;
                done_o   <= 1'b1;
            end
            if (go_i) begin
                we_q      <= we_i;
                wait_q    <= stall_i ? 2'h3 : 2'h0;
                bready_o  <= we_i && !stall_i;
                rready_o  <= !we_i && !stall_i;
                awvalid_o <= we_i;
                wvalid_o  <= we_i;
                arvalid_o <= !we_i;
                if (we_i) awaddr_o <= addr_i;
                if (we_i) wdata_o <= wdata_i;
                if (!we_i) araddr_o <= addr_i;
            end
        end
    end
endmodule

// ### sim/drs_rec_builder_tb.sv
// Self-checking bench of the diagnostic record builder
`timescale 1ns/10ps
module drs_rec_builder_tb;
    import drs_pkg::*;
    logic        mclk_i;
    logic        rst_i;
    logic [31:0] base_rec;
    logic [2:0]  grp_err;
    logic [1:0]  fm_err;
    logic [9:0]  in_lost;
    logic [1:0]  int_lost;
    logic        go, we, stall, done, irq;
    logic [7:0]  addr, awaddr, araddr;
    logic [31:0] wd, rdat, wdata, rdata;
    logic [1:0]  resp, bresp, rresp;
    logic [3:0]  wstrb;
    logic        aw_v, aw_r, w_v, w_r, b_v, b_r, ar_v, ar_r, r_v, r_r;
    logic [11:0] exp_st;
    int          err_count;
    int          checks_done;

    drs_rec_builder i_dut (.mclk_i(mclk_i), .rst_i(rst_i), .base_rec_i(base_rec), .grp_err_i(grp_err),
        .fm_err_i(fm_err), .in_lost_i(in_lost), .int_lost_i(int_lost), .s_axi_awvalid(aw_v),
        .s_axi_awready(aw_r), .s_axi_awaddr(awaddr), .s_axi_wvalid(w_v), .s_axi_wready(w_r),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(b_v), .s_axi_bready(b_r),
        .s_axi_bresp(bresp), .s_axi_arvalid(ar_v), .s_axi_arready(ar_r), .s_axi_araddr(araddr),
        .s_axi_rvalid(r_v), .s_axi_rready(r_r), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .irq_o(irq));
    drs_cpu_mdl i_cpu (.mclk_i(mclk_i), .rst_i(rst_i), .go_i(go), .we_i(we), .stall_i(stall), .addr_i(addr),
        .wdata_i(wd), .done_o(done), .rdata_o(rdat), .resp_o(resp), .awvalid_o(aw_v), .awready_i(aw_r),
        .awaddr_o(awaddr), .wvalid_o(w_v), .wready_i(w_r), .wdata_o(wdata), .wstrb_o(wstrb),
        .bvalid_i(b_v), .bready_o(b_r), .bresp_i(bresp), .arvalid_o(ar_v), .arready_i(ar_r),
        .araddr_o(araddr), .rvalid_i(r_v), .rready_o(r_r), .rdata_i(rdata), .rresp_i(rresp));

    initial begin
        mclk_i = 1'b0;
        forever #2.5 mclk_i = ~mclk_i;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("Checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic [1:0] rs);
        int n;
        @(posedge mclk_i);
        go    <= 1'b1;
        we    <= w;
        addr  <= a;
        wd    <= d;
        stall <= 1'($urandom);
        @(posedge mclk_i);
        go <= 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 50) begin
            @(posedge mclk_i);
            n++;
        end
        if (n >= 50) check("bus_done", 32'h0, 32'h1);
        rd = rdat;
        rs = resp;
    endtask

    function automatic logic [7:0] spread4(input logic [3:0] x);
        return {1'b0, x[3], 1'b0, x[2], 1'b0, x[1], 1'b0, x[0]};
    endfunction

    function automatic logic [31:0] exp_word(input int w, input logic pwm, input logic more);
        logic [7:0] b7;
        b7 = {2'b00, pwm ? 2'b00 : fm_err, 1'b0, grp_err};
        case (w)
            0: return base_rec;
            1: return {b7, DRS_NUM_CH, DRS_BITS_PER_CH, more, DRS_TYPE_DI};
            2: return {8'h00, spread4({2'b00, exp_st[9:8]}), spread4(exp_st[7:4]), spread4(exp_st[3:0])};
            default: return pwm ? 32'h0 : {16'h0, 7'h0, exp_st[11], 7'h0, exp_st[10]};
        endcase
    endfunction

    initial begin
        #100000;
        check("watchdog", 32'h0, 32'h1);
        give_verdict();
    end

    initial begin
        logic [31:0] rd;
        logic [1:0]  rs;
        logic [11:0] ev;
        logic [11:0] ien;
        logic [11:0] clr;
        logic        pwm;
        logic        more;
        err_count = 0;
        checks_done = 0;
        rst_i = 1'b1;
        {go, we, stall, addr, wd} = '0;
        {base_rec, grp_err, fm_err, in_lost, int_lost} = '0;
        exp_st = 12'h000;
        rd = $urandom(32'hA2AC);
        repeat (10) @(posedge mclk_i);
        rst_i <= 1'b0;
        // Control, status, enable and clear start at zero
        for (int i = 4; i < 8; i++) begin
            bus(1'b0, 8'(4 * i), 32'h0, rd, rs);
            check("reset_reg", rd, 32'h0);
            check("rd_resp", 32'(rs), 32'(DRS_RESP_OKAY));
        end
        bus(1'b0, 8'h20, 32'h0, rd, rs);
        check("unmapped_rd", 32'(rs), 32'(DRS_RESP_SLVERR));
        bus(1'b1, DRS_REG_REC1, 32'hFFFF_FFFF, rd, rs);
        check("ro_wr", 32'(rs), 32'(DRS_RESP_SLVERR));
        for (int i = 0; i < 40; i++) begin
            pwm  = 1'($urandom);
            more = 1'($urandom);
            bus(1'b1, DRS_REG_CTRL, {30'h0, more, pwm}, rd, rs);
            check("ctrl_resp", 32'(rs), 32'(DRS_RESP_OKAY));
            ev = (i < 2) ? 12'hFFF : 12'($urandom & $urandom);
            @(posedge mclk_i);
            base_rec <= $urandom;
            grp_err  <= 3'($urandom);
            fm_err   <= 2'($urandom);
            in_lost  <= ev[9:0];
            int_lost <= ev[11:10];
            @(posedge mclk_i);
            in_lost  <= 10'h000;
            int_lost <= 2'h0;
            exp_st = exp_st | (ev & (pwm ? 12'h3FF : 12'hFFF));
            for (int w = 0; w < 4; w++) begin
                bus(1'b0, 8'(4 * w), 32'h0, rd, rs);
                check("rec_word", rd, exp_word(w, pwm, more));
            end
            bus(1'b0, DRS_REG_STAT, 32'h0, rd, rs);
            check("status", rd, 32'(exp_st));
            ien = (i == 3) ? 12'h000 : 12'($urandom);
            bus(1'b1, DRS_REG_IEN, 32'(ien), rd, rs);
            check("ien_resp", 32'(rs), 32'(DRS_RESP_OKAY));
            @(posedge mclk_i);
            check("irq", 32'(irq), 32'(|(exp_st & ien)));
            clr = (i == 5) ? 12'hFFF : 12'($urandom);
            bus(1'b1, DRS_REG_ICLR, 32'(clr), rd, rs);
            exp_st = exp_st & ~clr;
            @(posedge mclk_i);
            check("irq_clr", 32'(irq), 32'(|(exp_st & ien)));
        end
        give_verdict();
    end
endmodule
